// >>> core/lcd_timing_pkg.sv
`default_nettype none
package lcd_timing_pkg;
    // ------------------------------------------------------------------
    // Register map (byte addresses, word aligned)
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_MODE   = 5'h00;
    localparam logic [4:0] OFS_BYTES  = 5'h04;
    localparam logic [4:0] OFS_ROWS   = 5'h08;
    localparam logic [4:0] OFS_PULSE  = 5'h0C;
    localparam logic [4:0] OFS_DIV    = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;

    // ------------------------------------------------------------------
    // Mode code fields
    // ------------------------------------------------------------------
    localparam int MODE_WIDE_BIT = 2;
    localparam int MODE_GRAY_BIT = 3;
    localparam int MODE_OR_BIT   = 4;
    localparam int MODE_DUAL_BIT = 5;
    localparam int MODE_EN_BIT   = 7;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_MODE  = 8'h00;
    localparam logic [7:0] RST_BYTES = 8'h27;
    localparam logic [9:0] RST_ROWS  = 10'h0EF;
    localparam logic [7:0] RST_PULSE = 8'h29;
    localparam logic [7:0] RST_DIV   = 8'h00;
    localparam logic [8:0] DIV_BASE  = 9'h002;
    localparam logic [1:0] GAP_HALVES = 2'h1;

    // Status fields
    localparam int ST_ROW_LSB   = 0;
    localparam int ST_ACTIVE    = 16;
    localparam int ST_UNDERRUN  = 17;

    // Pulse width adjust: plus half, minus half, or none
    typedef enum logic [1:0] {ADJ_PLUS, ADJ_MINUS, ADJ_NONE} adj_t;
endpackage
`default_nettype wire

// >>> core/pixel_skid_buffer.sv
`default_nettype none
module pixel_skid_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rstSync_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0]      count;
    logic [PW-1:0]    wrPtr;
    logic [PW-1:0]    rdPtr;
    logic             push;
    logic             pop;

    // ------------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------------
    assign inReady  = (count != (PW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;
    assign outData  = store[rdPtr];

    // Pointers wrap at depth; depth need not be a power of two
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            count <= '0;
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == PW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == PW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Storage needs no reset; valid gates it
    always_ff @(posedge clk) begin
        if (push) begin
            store[wrPtr] <= inData;
        end
    end
endmodule
`default_nettype wire

// >>> core/lcd_panel_timing_config.sv
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`default_nettype none
module lcd_panel_timing_config (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Pixel byte stream from the fetch side
    input  wire logic        pixValid,
    output logic             pixReady,
    input  wire logic [7:0]  pixData,
    // Panel pins
    output logic             line_pulse,
    output logic             shift_clock,
    output logic             framePulse,
    output logic      [7:0]  panelData
);
    typedef enum {ST_IDLE, ST_PULSE, ST_GAP, ST_XFER} state_t;

    // ------------------------------------------------------------------
    // Mode decode helpers
    // ------------------------------------------------------------------
    // Shift clock half period in reference ticks (1, 2 or 4)
    function automatic logic [2:0] halfTicks(input logic [7:0] m);
        logic wide;
        logic gray;
        logic orf;
        logic dual;
        wide = m[lcd_timing_pkg::MODE_WIDE_BIT];
        gray = m[lcd_timing_pkg::MODE_GRAY_BIT];
        orf  = m[lcd_timing_pkg::MODE_OR_BIT];
        dual = m[lcd_timing_pkg::MODE_DUAL_BIT];
        if (dual) begin
            halfTicks = gray ? 3'h4 : 3'h2;
        end else if (orf) begin
            halfTicks = (gray | wide) ? 3'h4 : 3'h2;
        end else begin
            halfTicks = (gray | wide) ? 3'h2 : 3'h1;
        end
    endfunction

    function automatic lcd_timing_pkg::adj_t pulseAdj(input logic [7:0] m);
        logic wide;
        logic gray;
        logic orf;
        logic dual;
        wide = m[lcd_timing_pkg::MODE_WIDE_BIT];
        gray = m[lcd_timing_pkg::MODE_GRAY_BIT];
        orf  = m[lcd_timing_pkg::MODE_OR_BIT];
        dual = m[lcd_timing_pkg::MODE_DUAL_BIT];
        if (gray) begin
            pulseAdj = lcd_timing_pkg::ADJ_PLUS;
        end else if (dual | (orf & ~wide)) begin
            pulseAdj = lcd_timing_pkg::ADJ_MINUS;
        end else if (orf) begin
            pulseAdj = lcd_timing_pkg::ADJ_NONE;
        end else begin
            pulseAdj = lcd_timing_pkg::ADJ_PLUS;
        end
    endfunction

    // Binary 4-bit single scan: one byte spans two shift clocks
    function automatic logic splitByte(input logic [7:0] m);
        splitByte = ~m[lcd_timing_pkg::MODE_WIDE_BIT] & ~m[lcd_timing_pkg::MODE_GRAY_BIT]
                  & ~m[lcd_timing_pkg::MODE_DUAL_BIT];
    endfunction

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rstMeta_n;
    logic rstSync_n;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] display_mode_code;
    logic [7:0] line_byte_count;
    logic [9:0] rows_per_frame;
    logic [7:0] line_pulse_width;
    logic [7:0] reference_clock_divider;
    logic       busAck;
    logic       underrun;
    logic       underrunEvent;
    logic [9:0] rowCount;
    state_t     state;
    logic       wrStrobe;

    // One wait cycle per access keeps read data registered
    assign avs_waitrequest = (avs_read | avs_write) & ~busAck;
    assign wrStrobe        = avs_write & busAck;

    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            busAck <= 1'b0;
        end else begin
            busAck <= (avs_read | avs_write) & ~busAck;
        end
    end

    // Config writes; fields sit in low bits, upper bits ignored
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            display_mode_code       <= lcd_timing_pkg::RST_MODE;
            line_byte_count         <= lcd_timing_pkg::RST_BYTES;
            rows_per_frame          <= lcd_timing_pkg::RST_ROWS;
            line_pulse_width        <= lcd_timing_pkg::RST_PULSE;
            reference_clock_divider <= lcd_timing_pkg::RST_DIV;
        end else if (wrStrobe) begin
            unique case (avs_address)
                lcd_timing_pkg::OFS_MODE:  display_mode_code       <= avs_writedata[7:0];
                lcd_timing_pkg::OFS_BYTES: line_byte_count         <= avs_writedata[7:0];
                lcd_timing_pkg::OFS_ROWS:  rows_per_frame          <= avs_writedata[9:0];
                lcd_timing_pkg::OFS_PULSE: line_pulse_width        <= avs_writedata[7:0];
                lcd_timing_pkg::OFS_DIV:   reference_clock_divider <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // Sticky underrun, write one to clear; a new event beats the clear
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            underrun <= 1'b0;
        end else if (underrunEvent) begin
            underrun <= 1'b1;
        end else if (wrStrobe && avs_address == lcd_timing_pkg::OFS_STATUS
                     && avs_writedata[lcd_timing_pkg::ST_UNDERRUN]) begin
            underrun <= 1'b0;
        end
    end

    // Read data loaded in the wait cycle, stands at the accepting edge
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !busAck) begin
            unique case (avs_address)
                lcd_timing_pkg::OFS_MODE:  avs_readdata <= {24'h000000, display_mode_code};
                lcd_timing_pkg::OFS_BYTES: avs_readdata <= {24'h000000, line_byte_count};
                lcd_timing_pkg::OFS_ROWS:  avs_readdata <= {22'h000000, rows_per_frame};
                lcd_timing_pkg::OFS_PULSE: avs_readdata <= {24'h000000, line_pulse_width};
                lcd_timing_pkg::OFS_DIV:   avs_readdata <= {24'h000000, reference_clock_divider};
                lcd_timing_pkg::OFS_STATUS: begin
                    avs_readdata <= 32'h0000_0000;
                    avs_readdata[lcd_timing_pkg::ST_ROW_LSB +: 10] <= rowCount;
                    avs_readdata[lcd_timing_pkg::ST_ACTIVE]        <= (state != ST_IDLE);
                    avs_readdata[lcd_timing_pkg::ST_UNDERRUN]      <= underrun;
                end
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pixel buffer
    // ------------------------------------------------------------------
    logic       bufValid;
    logic       bufReady;
    logic [7:0] bufData;

    // A stalled panel side backs up into the fetch side, no byte lost
    pixel_skid_buffer #(
        .WIDTH (8),
        .DEPTH (2)
    ) u_buffer (
        .clk       (ref_clk),
        .rstSync_n (rstSync_n),
        .inValid   (pixValid),
        .inReady   (pixReady),
        .inData    (pixData),
        .outValid  (bufValid),
        .outReady  (bufReady),
        .outData   (bufData)
    );

    // ------------------------------------------------------------------
    // Tick dividers
    // ------------------------------------------------------------------
    logic [8:0] refCount;
    logic [8:0] refRatio;
    logic       refTick;
    logic [2:0] halfCount;
    logic       halfTick;
    logic       enabled;

    assign enabled  = display_mode_code[lcd_timing_pkg::MODE_EN_BIT];
    assign refRatio = lcd_timing_pkg::DIV_BASE + {1'b0, reference_clock_divider};
    assign refTick  = enabled && (refCount == refRatio - 9'h001);
    assign halfTick = refTick && (halfCount == halfTicks(display_mode_code) - 3'h1);

    // Reference clock enable from the input clock
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            refCount <= '0;
        end else if (!enabled || refTick) begin
            refCount <= '0;
        end else begin
            refCount <= refCount + 9'h001;
        end
    end

    // Half shift-clock enable from the reference clock
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            halfCount <= '0;
        end else if (!enabled || halfTick) begin
            halfCount <= '0;
        end else if (refTick) begin
            halfCount <= halfCount + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Line sequencer
    // ------------------------------------------------------------------
    logic [10:0] pulseHalves;
    logic [10:0] phaseCount;
    logic [8:0]  beatTotal;
    logic [8:0]  beatCount;
    logic        clkHigh;
    logic        lowNibble;
    logic        beatStart;
    logic        lastBeat;
    logic        lastRow;

    // Width parameter is twice the field; pulse in half shift clocks
    always_comb begin
        pulseHalves = {1'b0, line_pulse_width, 2'b00};
        unique case (pulseAdj(display_mode_code))
            lcd_timing_pkg::ADJ_PLUS:  pulseHalves = pulseHalves + 11'h001;
            lcd_timing_pkg::ADJ_MINUS: pulseHalves = (pulseHalves == '0) ? 11'h001
                                                    : pulseHalves - 11'h001;
            lcd_timing_pkg::ADJ_NONE:  pulseHalves = (pulseHalves == '0) ? 11'h001
                                                    : pulseHalves;
        endcase
    end

    // Shift clocks per line from the byte count
    assign beatTotal = splitByte(display_mode_code)
                     ? {line_byte_count, 1'b0} + 9'h002
                     : {1'b0, line_byte_count} + 9'h001;
    assign beatStart = (state == ST_XFER) && halfTick && !clkHigh;
    assign lastBeat  = (beatCount == beatTotal - 9'h001);
    assign lastRow   = (rowCount == rows_per_frame);
    // A byte leaves the buffer when its last nibble is shifted
    assign bufReady  = beatStart && bufValid
                     && (!splitByte(display_mode_code) || lowNibble);
    assign underrunEvent = (state == ST_XFER) && halfTick && !clkHigh && !bufValid;

    // Line: pulse, gap, transfer; frame is rows of lines
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state      <= ST_IDLE;
            phaseCount <= '0;
        end else if (!enabled) begin
            state      <= ST_IDLE;
            phaseCount <= '0;
        end else if (halfTick) begin
            unique case (state)
                ST_IDLE: begin
                    state      <= ST_PULSE;
                    phaseCount <= '0;
                end
                ST_PULSE: begin
                    if (phaseCount == pulseHalves - 11'h001) begin
                        state      <= ST_GAP;
                        phaseCount <= '0;
                    end else begin
                        phaseCount <= phaseCount + 11'h001;
                    end
                end
                ST_GAP: begin
                    if (phaseCount == {9'h000, lcd_timing_pkg::GAP_HALVES} - 11'h001) begin
                        state      <= ST_XFER;
                        phaseCount <= '0;
                    end else begin
                        phaseCount <= phaseCount + 11'h001;
                    end
                end
                ST_XFER: begin
                    if (clkHigh && lastBeat) begin
                        state <= ST_PULSE;
                    end
                end
            endcase
        end
    end

    // Shift clock runs only in transfer; a missing byte holds it low
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            clkHigh   <= 1'b0;
            beatCount <= '0;
            lowNibble <= 1'b0;
        end else if (state != ST_XFER) begin
            clkHigh   <= 1'b0;
            beatCount <= '0;
            lowNibble <= 1'b0;
        end else if (halfTick) begin
            if (clkHigh) begin
                clkHigh   <= 1'b0;
                beatCount <= beatCount + 9'h001;
            end else if (bufValid) begin
                clkHigh   <= 1'b1;
                lowNibble <= splitByte(display_mode_code) & ~lowNibble;
            end
        end
    end

    // Row counter counts line pulses, wraps after the programmed rows
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            rowCount <= '0;
        end else if (!enabled) begin
            rowCount <= '0;
        end else if (halfTick && state == ST_XFER && clkHigh && lastBeat) begin
            rowCount <= lastRow ? 10'h000 : rowCount + 10'h001;
        end
    end

    // ------------------------------------------------------------------
    // Panel outputs, all from flip-flops
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            line_pulse  <= 1'b0;
            shift_clock <= 1'b0;
            framePulse  <= 1'b0;
        end else begin
            line_pulse  <= (state == ST_PULSE);
            shift_clock <= clkHigh && (state == ST_XFER);
            framePulse  <= (state == ST_PULSE) && (rowCount == 10'h000);
        end
    end

    // Data changes only at the rising half, stable while clock high
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            panelData <= 8'h00;
        end else if (bufReady || (beatStart && bufValid)) begin
            if (display_mode_code[lcd_timing_pkg::MODE_WIDE_BIT]) begin
                panelData <= bufData;
            end else if (display_mode_code[lcd_timing_pkg::MODE_DUAL_BIT]) begin
                panelData <= bufData;
            end else if (splitByte(display_mode_code)) begin
                panelData <= {4'h0, lowNibble ? bufData[3:0] : bufData[7:4]};
            end else begin
                panelData <= {4'h0, bufData[3:0]};
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/lcd_timing_props.sv
`default_nettype none
// ------------------------------------------------------------
// Panel and bus checks seen from the top ports
// ------------------------------------------------------------
module lcd_timing_props (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        line_pulse,
    input wire logic        shift_clock,
    input wire logic        framePulse,
    input wire logic [7:0]  panelData
);
    logic [7:0] mode;
    logic [7:0] pw;
    logic [7:0] dv;
    int         lpCnt;
    int         expLp;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Shadow copy of settings, taken on the accept edge only
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= lcd_timing_pkg::RST_MODE;
            pw   <= lcd_timing_pkg::RST_PULSE;
            dv   <= lcd_timing_pkg::RST_DIV;
        end else if (avs_write && !avs_waitrequest) begin
            if (avs_address == lcd_timing_pkg::OFS_MODE) mode <= avs_writedata[7:0];
            if (avs_address == lcd_timing_pkg::OFS_PULSE) pw <= avs_writedata[7:0];
            if (avs_address == lcd_timing_pkg::OFS_DIV) dv <= avs_writedata[7:0];
        end
    end
    // High time of the line pulse, in ref_clk cycles
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) lpCnt <= 0;
        else lpCnt <= line_pulse ? lpCnt + 1 : 0;
    end
    // Plus-half width: P halves, one tick per half, ratio div+2
    assign expLp = (4 * int'(pw) + 1) * (int'(dv) + 2);
    a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait cycle on new request");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait cycle");
    a_hole_zero: assert property (avs_read && !avs_waitrequest && avs_address > 5'h14
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_pulse_quiet: assert property (line_pulse |-> !shift_clock)
        else $error("shift clock during line pulse");
    a_frame_inside: assert property (framePulse |-> line_pulse)
        else $error("frame pulse outside line pulse");
    a_nibble_low: assert property (mode == 8'h83 && shift_clock |-> panelData[7:4] == 4'h0)
        else $error("upper nibble driven in 4-bit mode");
    a_shift_div2: assert property ($rose(shift_clock) && mode == 8'h83 && dv == 8'h00
        |-> ##1 shift_clock ##1 !shift_clock) else $error("shift high time wrong at ratio 2");
    a_shift_div4: assert property ($rose(shift_clock) && mode == 8'h83 && dv == 8'h02
        |-> shift_clock [*4] ##1 !shift_clock) else $error("shift high time wrong at ratio 4");
    a_pulse_width: assert property ($fell(line_pulse) && mode == 8'h83 |-> lpCnt == expLp)
        else $error("line pulse width wrong");
endmodule
bind lcd_panel_timing_config lcd_timing_props u_props (.ref_clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .line_pulse,
    .shift_clock, .framePulse, .panelData);
`default_nettype wire

// >>> dv/lcd_panel_model.sv
`default_nettype none
// ------------------------------------------------------------
// Panel: latches data on shift rise, counts beats and lines
// ------------------------------------------------------------
module lcd_panel_model (
    input  wire logic       ref_clk,
    input  wire logic       line_pulse,
    input  wire logic       shift_clock,
    input  wire logic       framePulse,
    input  wire logic [7:0] panelData,
    output int              nShift,
    output int              nLine,
    output int              scPer,
    output int              lpLen,
    output logic     [31:0] dFirst
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pSc;
    logic pLp;
    logic pFp;
    int   curSh = 0;
    int   curLn = 0;
    int   scCnt = 0;
    int   lpCnt = 0;
    // Sampled on ref_clk so pins and data are read after they settle
    always @(posedge ref_clk) begin
        pSc <= shift_clock;
        pLp <= line_pulse;
        pFp <= framePulse;
        scCnt <= scCnt + 1;
        lpCnt <= line_pulse ? lpCnt + 1 : 0;
        if (shift_clock && !pSc) begin
            if (curSh < 4) dFirst[curSh*8 +: 8] <= panelData;
            curSh <= curSh + 1;
            scPer <= scCnt;
            scCnt <= 1;
        end
        if (line_pulse && !pLp) begin
            nShift <= curSh;
            curSh  <= 0;
            curLn  <= (framePulse && !pFp) ? 1 : curLn + 1;
        end
        if (framePulse && !pFp) nLine <= curLn;
        if (!line_pulse && pLp) lpLen <= lpCnt;
    end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        pixValid = 1'b0;
    logic        pixReady;
    logic [7:0]  pixData = 8'h00;
    logic        feedOn = 1'b0;
    logic        line_pulse;
    logic        shift_clock;
    logic        framePulse;
    logic [7:0]  panelData;
    logic [31:0] rd;
    logic [31:0] dFirst;
    int          nShift;
    int          nLine;
    int          scPer;
    int          lpLen;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    lcd_panel_timing_config dut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .pixValid, .pixReady, .pixData,
        .line_pulse, .shift_clock, .framePulse, .panelData);
    lcd_panel_model model (.ref_clk, .line_pulse, .shift_clock, .framePulse, .panelData,
        .nShift, .nLine, .scPer, .lpLen, .dFirst);
    initial forever #5 ref_clk = ~ref_clk;
    // Byte source: counting pattern, advances only on a taken beat
    always @(posedge ref_clk) begin
        pixValid <= feedOn;
        if (pixValid && pixReady) pixData <= pixData + 8'h01;
    end
    // One bus access; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        @(posedge ref_clk);
        // Only the watchdog ends a wait that never answers
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wf(input int n);
        repeat (n) @(posedge framePulse);
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic t_regs;
        logic [4:0]  ofs [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h18};
        logic [31:0] ev [6] = '{32'h0, 32'h27, 32'hEF, 32'h29, 32'h0, 32'h0};
        bus(1'b1, 5'h18, 32'hFF);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, ofs[i], 32'h0);
            `CHK(rd, ev[i])
        end
    endtask
    // Panel idle, so the buffer must refuse after two bytes
    task automatic t_fill;
        feedOn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        `CHK(pixReady, 1'b0)
    endtask
    // Four bytes a line, four lines a frame, pulse field 1, ratio 2
    task automatic t_modes;
        logic [7:0] md [4] = '{8'h83, 8'h87, 8'h8B, 8'hA3};
        int eN [4] = '{8, 4, 4, 4};
        int eLp [4] = '{10, 20, 20, 12};
        int eSc [4] = '{4, 8, 8, 8};
        bus(1'b1, 5'h04, 32'h3);
        bus(1'b1, 5'h08, 32'h3);
        bus(1'b1, 5'h0C, 32'h1);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 5'h00, 32'h0);
            bus(1'b1, 5'h00, {24'h0, md[i]});
            wf(3);
            `CHK(nShift, eN[i])
            `CHK(lpLen, eLp[i])
            `CHK(scPer, eSc[i])
            `CHK(nLine, 4)
            if (i == 0) begin
                `CHK(dFirst[7:4] | dFirst[15:12], 4'h0)
                `CHK({dFirst[3:0], dFirst[11:8]} + 8'h01, {dFirst[19:16], dFirst[27:24]})
            end else if (i == 2) `CHK(dFirst[11:8], dFirst[3:0] + 4'h1)
            else `CHK(dFirst[15:8], dFirst[7:0] + 8'h01)
        end
    endtask
    // Ratio 4 doubles every period; two rows is the short frame
    task automatic t_div;
        bus(1'b1, 5'h00, 32'h0);
        bus(1'b1, 5'h10, 32'h2);
        bus(1'b1, 5'h08, 32'h1);
        bus(1'b1, 5'h00, 32'h83);
        wf(3);
        `CHK(scPer, 8)
        `CHK(lpLen, 20)
        `CHK(nLine, 2)
    endtask
    // Starved source flags underrun; write-one clears it
    // A stalled line sends no further pulses, so wait cycles, not frames
    task automatic t_stall;
        feedOn <= 1'b0;
        repeat (200) @(posedge ref_clk);
        `CHK(shift_clock, 1'b0)
        bus(1'b0, 5'h14, 32'h0);
        `CHK(rd[17:16], 2'h3)
        feedOn <= 1'b1;
        wf(1);
        bus(1'b1, 5'h14, 32'h20000);
        bus(1'b0, 5'h14, 32'h0);
        `CHK(rd[17:16], 2'h1)
    endtask
    task automatic stop_test;
        if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Whole run is a few thousand cycles; this limit is generous
    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_regs();
        t_fill();
        t_modes();
        t_div();
        t_stall();
        stop_test();
    end
endmodule
`default_nettype wire
